// ===== fsr_ctrl_model.sv
// Purpose: System controller on the disable/fault pin
// Assumes: Pin pulled up, device pulls it low while oe_n is low
// Notes: Counts rising pin edges during fault mode
`timescale 1ns/1ps
// ======
// Controller model
// ======
module fsr_ctrl_model (
  input wire logic i_ref_clk,
  input wire logic i_oe_n, // Device pull-down, active low
  input wire logic i_pull_low, // Controller disables the device
  input wire logic i_fa, // Device in fault mode
  input wire logic i_clr, // Clears the edge count
  output logic o_pin,
  output int o_edges
);
  logic pin_q; // Level at the last edge
  // Pull-up wins only when nobody pulls
  assign o_pin = i_oe_n & ~i_pull_low;
  // 40 ns sampling easily resolves 10 us pulses
  always @(posedge i_ref_clk) begin
    pin_q <= o_pin;
    if (i_clr) o_edges <= 0;
    else if (i_fa && o_pin && !pin_q) o_edges <= o_edges + 1;
  end
endmodule : fsr_ctrl_model

// ===== fsr_monitor.sv
// Purpose: Port checker for fsr_supervisor
// Assumes: Bound to every fsr_supervisor instance
// Notes: Pulse widths are measured by a helper counter
`timescale 1ns/1ps
// ======
// Checker
// ======
module fsr_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_disable_fault_pin,
  input wire logic i_thermal_over,
  input wire logic o_disable_fault_pin_oe_n,
  input wire logic o_switch_enable,
  input wire logic o_regulator_enable,
  input wire logic o_freq_pin_hold,
  input wire logic o_fault_active,
  input wire logic [fsr_pkg::NUM_FAULTS-1:0] o_fault_flags
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [11:0] hi_r; // Released cycles in a row
  // Count release time; wraps outside fault mode, unused there
  always_ff @(posedge i_ref_clk) begin
    hi_r <= o_disable_fault_pin_oe_n ? hi_r + 12'h001 : 12'h000;
  end
  sequence entry_s; $rose(o_fault_active); endsequence
  sequence pulled_s; !o_disable_fault_pin_oe_n [*8]; endsequence
  start_low_a: assert property (entry_s |-> pulled_s)
    else $error("pin not pulled at fault entry");
  fault_stop_a: assert property (o_fault_active |-> !o_switch_enable)
    else $error("switching in fault mode");
  ext_dis_a: assert property (!i_disable_fault_pin [*5] |-> !o_switch_enable)
    else $error("switching while pin low");
  thermal_stop_a: assert property (i_thermal_over [*6] |-> !o_switch_enable)
    else $error("switching while overheated");
  reg_on_a: assert property (o_regulator_enable)
    else $error("regulator dropped");
  freq_hold_a: assert property (o_fault_active == o_freq_pin_hold)
    else $error("frequency hold mismatch");
  trim_alone_a: assert property (o_fault_flags[8] |-> !(|o_fault_flags[7:0]))
    else $error("other flags beside trim");
  trim_keep_a: assert property (o_fault_flags[8] |=> o_fault_flags[8])
    else $error("trim flag cleared");
  pulse_width_a: assert property ($fell(o_disable_fault_pin_oe_n)
    && $past(o_fault_active) && o_fault_active |->
    hi_r == fsr_pkg::PULSE_HALF_CYC || hi_r == fsr_pkg::LEAD_HIGH_CYC)
    else $error("bad release width");
endmodule : fsr_monitor
bind fsr_supervisor fsr_monitor mon (.*);

// ===== fsr_pkg.sv
// Purpose: Shared constants for the fault supervisor with automatic retry
// Assumes: Reference clock of 25 MHz, period 40 ns
// Notes: Times are kept in their own unit, cycle counts derive from them

// ==========================================================================
// Package
// ==========================================================================
package fsr_pkg;

  // Reference clock period
  localparam int CLK_PERIOD_NS = 40;

  // Qualification times, as specified
  localparam int SUST_OC_US = 2100;          // Accumulated 2.1 ms
  localparam int PEAK_OC_NS = 100;           // Continuous, more than 100 ns
  localparam int INPUT_OV_NS = 1300;         // Longer than 1.3 us

  // Fault code signalling times
  localparam int PULSE_HALF_NS = 10000;      // Half period of 50 kHz
  localparam int START_DELAY_NS = 10000;     // Fault to first edge, 10 us
  localparam int LEAD_HIGH_NS = 100000;      // Leading high, 100 us
  localparam int RETRY_MS = 100;             // Time in fault mode

  // Least times round up to whole cycles
  localparam int SUST_OC_CYC =
    (SUST_OC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PEAK_OC_CYC =
    (PEAK_OC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INPUT_OV_CYC =
    (INPUT_OV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_HALF_CYC =
    (PULSE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_DELAY_CYC =
    (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_HIGH_CYC =
    (LEAD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC =
    (RETRY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-up sequence length before switching may start
  localparam int POWERUP_CYC = 32;

  // Fault bit positions; code sent is position plus one
  localparam int NUM_FAULTS = 9;
  localparam int FB_SUST_OC = 0;
  localparam int FB_PEAK_OC = 1;
  localparam int FB_INPUT_OV = 2;
  localparam int FB_THERMAL = 3;
  localparam int FB_PROG_RANGE = 4;
  localparam int FB_PROG_OPEN = 5;
  localparam int FB_PROG_SHORT = 6;
  localparam int FB_FREQ_SHORT = 7;
  localparam int FB_TRIM = 8;

  // Width of the phase timer, covers the longest phase
  localparam int TMR_W = 12;

  // Reset values
  localparam logic [NUM_FAULTS-1:0] FLAGS_RST = 9'h000;
  localparam logic [TMR_W-1:0] TMR_RST = 12'h000;

  // Supervisor modes
  typedef enum logic [2:0] {
    ST_INIT,
    ST_DISABLED,
    ST_POWERUP,
    ST_RUN,
    ST_FLT_DELAY,
    ST_FLT_TX,
    ST_FLT_WAIT
  } fsr_state_type;

  // Fault code transmit phases
  typedef enum logic [1:0] {
    PH_LEAD,
    PH_SEP,
    PH_HIGH,
    PH_LOW
  } fsr_phase_type;

endpackage : fsr_pkg

// ===== fsr_qualify.sv
// Purpose: Persistence qualifier for one comparator flag
// Assumes: Inputs already synchronised to the reference clock
// Notes: Hit is registered and stays while the count is at threshold and i_count stays high

`timescale 1ns/1ps

// ==========================================================================
// Qualifier
// ==========================================================================
module fsr_qualify #(
  parameter int THRESH = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_arm,
  input wire logic i_count,
  input wire logic i_clear,
  output logic o_hit
);

  localparam int CW = $clog2(THRESH + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(THRESH);

  // Refuse a threshold the counter cannot express
  generate
    if (THRESH < 1) begin : g_bad_thresh
      $error("fsr_qualify threshold must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_r;                      // Cycles seen so far

  // ========================================================================
  // Counter
  // ========================================================================
  // Saturates so a long condition never wraps back to zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_arm || i_clear) begin
      cnt_r <= '0;
    end else if (i_count && cnt_r != CNT_MAX) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // ========================================================================
  // Hit flag
  // ========================================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_arm || i_clear) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_count && (cnt_r >= CNT_MAX - CW'(1));
    end
  end

endmodule : fsr_qualify

// ===== fsr_supervisor.sv
// Purpose: Fault supervisor, mode control and fault code output
// Assumes: All comparator inputs and the pin are asynchronous
// Notes: Reset stands for supply power-on; pin is open drain
//
// What this block does
// - External low on pin disables, regulator stays on
// - Sustained overcurrent after accumulated 2.1 ms conduction
// - Build option suppresses sustained overcurrent action
// - Peak overcurrent after more than 100 ns
// - Thermal flag is an immediate fault
// - Overvoltage after more than 1.3 us
// - Program pin open fault after check done
// - Program pin short fault below 500 mV
// - Out-of-range fault during the programming check
// - Frequency pin short fault below 150 mV
// - Trim error reports alone, others ignored
// - Trim error latched until power cycle
// - Any fault stops switching, pulls pin low
// - After codes: low power, regulator, frequency hold
// - Fault number sent by toggling pull-down
// - Release pull-down after 100 ms in fault
// - Pin high again runs power-up sequence
// - Faults rechecked before switching; refault if present
// - Fault and retry cycle repeats without limit
// - Codes are 10 us pulses, one to nine
// - Start 10 us after fault, 100 us lead
// - Several codes sent in ascending order

`timescale 1ns/1ps

module fsr_supervisor #(
  parameter int SUST_OC_CYC = fsr_pkg::SUST_OC_CYC,
  parameter int RETRY_CYC = fsr_pkg::RETRY_CYC,
  parameter int POWERUP_CYC = fsr_pkg::POWERUP_CYC,
  parameter bit SUST_OC_ACTION = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_disable_fault_pin,
  input wire logic i_ls_overcurrent,
  input wire logic i_ls_conducting,
  input wire logic i_peak_overcurrent,
  input wire logic i_input_overvoltage,
  input wire logic i_thermal_over,
  input wire logic i_prog_check_active,
  input wire logic i_prog_check_done,
  input wire logic i_prog_in_range_band,
  input wire logic i_prog_above_open,
  input wire logic i_prog_below_short,
  input wire logic i_freq_pin_below_short,
  input wire logic i_trim_check_done,
  input wire logic i_trim_check_fail,
  output logic o_disable_fault_pin_out,
  output logic o_disable_fault_pin_oe_n,
  output logic o_switch_enable,
  output logic o_regulator_enable,
  output logic o_low_power,
  output logic o_freq_pin_hold,
  output logic o_fault_active,
  output logic [fsr_pkg::NUM_FAULTS-1:0] o_fault_flags
);

  localparam int NF = fsr_pkg::NUM_FAULTS;
  localparam int NS = 14;                    // Synchronised inputs
  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam int PW = $clog2(POWERUP_CYC + 1);
  localparam logic [3:0] NO_CODE = 4'hF;

  // Refuse counts the logic cannot serve
  generate
    if (RETRY_CYC < 2 || POWERUP_CYC < 1 || SUST_OC_CYC < 1) begin : g_bad
      $error("fsr_supervisor counts too small");
    end
  endgenerate

  // ========================================================================
  // Next set fault at or above a start position
  // ========================================================================
  function automatic logic [3:0] next_code(input logic [NF-1:0] flags,
                                           input logic [3:0] start);
    logic [3:0] res;
    res = NO_CODE;
    for (int k = NF - 1; k >= 0; k--) begin
      if (flags[k] && 4'(k) >= start) begin
        res = 4'(k);
      end
    end
    return res;
  endfunction : next_code

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  logic [NS-1:0] raw_in;                     // Asynchronous inputs
  logic [NS-1:0] sync1_r;                    // First stage, read by stage 2
  logic [NS-1:0] sync2_r;                    // Safe to use

  assign raw_in = {i_disable_fault_pin, i_ls_overcurrent, i_ls_conducting,
                   i_peak_overcurrent, i_input_overvoltage, i_thermal_over,
                   i_prog_check_active, i_prog_check_done,
                   i_prog_in_range_band, i_prog_above_open,
                   i_prog_below_short, i_freq_pin_below_short,
                   i_trim_check_done, i_trim_check_fail};

  // Two flops per input, each bit on its own
  generate
    for (genvar g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= raw_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  logic pin_s, lsoc_s, lscond_s, peak_s, ov_s, therm_s;
  logic pchk_s, pdone_s, prange_s, popen_s, pshort_s, fshort_s;
  logic tdone_s, tfail_s;
  assign {pin_s, lsoc_s, lscond_s, peak_s, ov_s, therm_s, pchk_s, pdone_s,
          prange_s, popen_s, pshort_s, fshort_s, tdone_s, tfail_s} =
         sync2_r;

  // ========================================================================
  // State declarations
  // ========================================================================
  fsr_pkg::fsr_state_type st_r, st_nxt;      // Supervisor mode
  fsr_pkg::fsr_phase_type ph_r;              // Transmit phase
  logic [fsr_pkg::TMR_W-1:0] tmr_r;          // Phase timer
  logic [RW-1:0] retry_r;                    // Time spent in fault mode
  logic [PW-1:0] pwr_r;                      // Power-up sequence timer
  logic [NF-1:0] flags_r;                    // Latched faults
  logic [3:0] code_r;                        // Fault position being sent
  logic [3:0] pulses_r;                      // Pulses sent of this code
  logic arm;                                 // Faults are being watched
  logic hit_sust, hit_peak, hit_ov;          // Qualified timed faults
  logic [NF-1:0] hits;                       // New faults this cycle
  logic [NF-1:0] tx_flags;                   // Faults to be reported
  logic any_fault;                           // Latched or new fault
  logic tx_done;                             // Last pulse of last code

  // Watch only while powering up or switching
  assign arm = (st_r == fsr_pkg::ST_POWERUP) || (st_r == fsr_pkg::ST_RUN);

  // ========================================================================
  // Fault qualifiers
  // ========================================================================
  // Count only in conduction; pause outside it, restart on a gap
  fsr_qualify #(.THRESH(SUST_OC_CYC)) u_sust_oc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_arm(arm),
    .i_count(lscond_s && lsoc_s),
    .i_clear(lscond_s && !lsoc_s),
    .o_hit(hit_sust)
  );

  // Peak current must be unbroken for the whole window
  fsr_qualify #(.THRESH(fsr_pkg::PEAK_OC_CYC)) u_peak_oc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_arm(arm),
    .i_count(peak_s),
    .i_clear(!peak_s),
    .o_hit(hit_peak)
  );

  // Filters short supply spikes
  fsr_qualify #(.THRESH(fsr_pkg::INPUT_OV_CYC)) u_input_ov (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_arm(arm),
    .i_count(ov_s),
    .i_clear(!ov_s),
    .o_hit(hit_ov)
  );

  // Collect new faults in code order
  always_comb begin
    hits = '0;
    hits[fsr_pkg::FB_SUST_OC] = hit_sust && SUST_OC_ACTION;
    hits[fsr_pkg::FB_PEAK_OC] = hit_peak;
    hits[fsr_pkg::FB_INPUT_OV] = hit_ov;
    hits[fsr_pkg::FB_THERMAL] = therm_s;
    hits[fsr_pkg::FB_PROG_RANGE] = pchk_s && prange_s;
    hits[fsr_pkg::FB_PROG_OPEN] = pdone_s && popen_s;
    hits[fsr_pkg::FB_PROG_SHORT] = pshort_s;
    hits[fsr_pkg::FB_FREQ_SHORT] = fshort_s;
    if (!arm) begin
      hits = '0;
    end
  end

  // Trim error hides every other fault
  assign tx_flags = flags_r[fsr_pkg::FB_TRIM] ?
                    (NF'(1) << fsr_pkg::FB_TRIM) : flags_r;
  assign any_fault = (|flags_r) || (|hits);

  // ========================================================================
  // Fault latches
  // ========================================================================
  // Flags hold until the recheck; trim error survives every retry
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_r <= fsr_pkg::FLAGS_RST;
    end else begin
      for (int k = 0; k < NF - 1; k++) begin
        if (hits[k]) begin
          flags_r[k] <= 1'b1;
        end else if (st_r == fsr_pkg::ST_DISABLED &&
                     st_nxt == fsr_pkg::ST_POWERUP) begin
          flags_r[k] <= 1'b0;
        end
      end
      if (tdone_s && tfail_s) begin
        flags_r[fsr_pkg::FB_TRIM] <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Mode sequencing
  // ========================================================================
  assign tx_done = (ph_r == fsr_pkg::PH_LOW) &&
                   (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::PULSE_HALF_CYC - 1)) &&
                   (pulses_r == code_r + 4'h1) &&
                   (next_code(tx_flags, code_r + 4'h1) == NO_CODE);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      // Pull-down held until the trim read is over
      fsr_pkg::ST_INIT: begin
        if (tdone_s && tfail_s) begin
          st_nxt = fsr_pkg::ST_FLT_DELAY;
        end else if (tdone_s) begin
          st_nxt = fsr_pkg::ST_DISABLED;
        end
      end
      // Released pin waits for the enable level
      fsr_pkg::ST_DISABLED: begin
        if (pin_s) begin
          st_nxt = fsr_pkg::ST_POWERUP;
        end
      end
      // Recheck during power-up, no switching yet
      fsr_pkg::ST_POWERUP: begin
        if (any_fault) begin
          st_nxt = fsr_pkg::ST_FLT_DELAY;
        end else if (!pin_s) begin
          st_nxt = fsr_pkg::ST_DISABLED;
        end else if (pwr_r == PW'(POWERUP_CYC - 1)) begin
          st_nxt = fsr_pkg::ST_RUN;
        end
      end
      fsr_pkg::ST_RUN: begin
        if (any_fault) begin
          st_nxt = fsr_pkg::ST_FLT_DELAY;
        end else if (!pin_s) begin
          st_nxt = fsr_pkg::ST_DISABLED;
        end
      end
      fsr_pkg::ST_FLT_DELAY: begin
        // Pin stays low one cycle into the transmit, so leave early
        if (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::START_DELAY_CYC - 2)) begin
          st_nxt = fsr_pkg::ST_FLT_TX;
        end
      end
      fsr_pkg::ST_FLT_TX: begin
        if (tx_done) begin
          st_nxt = fsr_pkg::ST_FLT_WAIT;
        end
      end
      // Retry forever; a release only comes after the code is out
      fsr_pkg::ST_FLT_WAIT: begin
        if (retry_r >= RW'(RETRY_CYC - 1)) begin
          st_nxt = fsr_pkg::ST_DISABLED;
        end
      end
      default: begin
        st_nxt = fsr_pkg::ST_INIT;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= fsr_pkg::ST_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Power-up timer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || st_r != fsr_pkg::ST_POWERUP) begin
      pwr_r <= '0;
    end else begin
      pwr_r <= pwr_r + PW'(1);
    end
  end

  // Time in fault mode, from entry; saturates at RETRY_CYC - 1
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || st_nxt == fsr_pkg::ST_FLT_DELAY &&
        st_r != fsr_pkg::ST_FLT_DELAY) begin
      retry_r <= '0;
    end else if (retry_r != RW'(RETRY_CYC - 1)) begin
      retry_r <= retry_r + RW'(1);
    end
  end

  // ========================================================================
  // Fault code transmitter
  // ========================================================================
  // Lead high, low gap, then high-low pulses, one per code step
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || st_r != st_nxt) begin
      tmr_r <= fsr_pkg::TMR_RST;
      ph_r <= fsr_pkg::PH_LEAD;
      pulses_r <= 4'h0;
      code_r <= next_code(tx_flags, 4'h0);
    end else if (st_r == fsr_pkg::ST_FLT_DELAY) begin
      tmr_r <= tmr_r + fsr_pkg::TMR_W'(1);
      code_r <= next_code(tx_flags, 4'h0);
    end else if (st_r == fsr_pkg::ST_FLT_TX) begin
      tmr_r <= tmr_r + fsr_pkg::TMR_W'(1);
      case (ph_r)
        fsr_pkg::PH_LEAD: begin
          if (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::LEAD_HIGH_CYC - 1)) begin
            tmr_r <= fsr_pkg::TMR_RST;
            ph_r <= fsr_pkg::PH_SEP;
          end
        end
        fsr_pkg::PH_SEP: begin
          if (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::PULSE_HALF_CYC - 1)) begin
            tmr_r <= fsr_pkg::TMR_RST;
            ph_r <= fsr_pkg::PH_HIGH;
          end
        end
        fsr_pkg::PH_HIGH: begin
          if (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::PULSE_HALF_CYC - 1)) begin
            tmr_r <= fsr_pkg::TMR_RST;
            ph_r <= fsr_pkg::PH_LOW;
            pulses_r <= pulses_r + 4'h1;
          end
        end
        fsr_pkg::PH_LOW: begin
          if (tmr_r == fsr_pkg::TMR_W'(fsr_pkg::PULSE_HALF_CYC - 1)) begin
            tmr_r <= fsr_pkg::TMR_RST;
            if (pulses_r != code_r + 4'h1) begin
              ph_r <= fsr_pkg::PH_HIGH;
            end else begin
              // Next code in ascending order behind a new lead
              ph_r <= fsr_pkg::PH_LEAD;
              pulses_r <= 4'h0;
              code_r <= next_code(tx_flags, code_r + 4'h1);
            end
          end
        end
        default: begin
          ph_r <= fsr_pkg::PH_LEAD;
        end
      endcase
    end
  end

  // ========================================================================
  // Pin drive
  // ========================================================================
  // Only ever pulls low; enable is low while pulling
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_disable_fault_pin_oe_n <= 1'b0;
    end else begin
      case (st_nxt)
        fsr_pkg::ST_INIT, fsr_pkg::ST_FLT_DELAY, fsr_pkg::ST_FLT_WAIT: begin
          o_disable_fault_pin_oe_n <= 1'b0;
        end
        fsr_pkg::ST_FLT_TX: begin
          // Released only once the transmit mode itself has started
          o_disable_fault_pin_oe_n <= (st_r == fsr_pkg::ST_FLT_TX) &&
                                      ((ph_r == fsr_pkg::PH_LEAD) ||
                                       (ph_r == fsr_pkg::PH_HIGH));
        end
        default: begin
          o_disable_fault_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // Mode outputs
  // ========================================================================
  // Switching follows the next mode so a fault stops it at once
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_disable_fault_pin_out <= 1'b0;
      o_switch_enable <= 1'b0;
      o_regulator_enable <= 1'b1;
      o_low_power <= 1'b0;
      o_freq_pin_hold <= 1'b0;
      o_fault_active <= 1'b0;
      o_fault_flags <= fsr_pkg::FLAGS_RST;
    end else begin
      o_disable_fault_pin_out <= 1'b0;
      o_switch_enable <= (st_nxt == fsr_pkg::ST_RUN);
      o_regulator_enable <= 1'b1;
      o_low_power <= (st_nxt == fsr_pkg::ST_FLT_WAIT) ||
                     (st_nxt == fsr_pkg::ST_DISABLED);
      o_freq_pin_hold <= (st_nxt == fsr_pkg::ST_FLT_DELAY) ||
                         (st_nxt == fsr_pkg::ST_FLT_TX) ||
                         (st_nxt == fsr_pkg::ST_FLT_WAIT);
      o_fault_active <= (st_nxt == fsr_pkg::ST_FLT_DELAY) ||
                        (st_nxt == fsr_pkg::ST_FLT_TX) ||
                        (st_nxt == fsr_pkg::ST_FLT_WAIT);
      o_fault_flags <= tx_flags;
    end
  end

endmodule : fsr_supervisor

// ===== tb_top.sv
// Purpose: Self-checking bench for fsr_supervisor
// Assumes: 25 MHz clock, shortened retry and overcurrent counts
// Notes: Rows hold stimulus, flags and pin edge counts
`timescale 1ns/1ps
// ======
// Bench
// ======
module tb_top;
  typedef struct {logic [7:0] st; logic [8:0] fl; int ed;} fsr_row_type;
  // Edges per code: one lead plus one per pulse
  fsr_row_type rows [9] = '{'{8'h01, 9'h001, 2}, '{8'h02, 9'h002, 3},
    '{8'h04, 9'h004, 4}, '{8'h08, 9'h008, 5}, '{8'h10, 9'h010, 6},
    '{8'h20, 9'h020, 7}, '{8'h40, 9'h040, 8}, '{8'h80, 9'h080, 9},
    '{8'h48, 9'h048, 13}};
  logic clk = 1'b0, rst = 1'b1, pull_low = 1'b0, clr = 1'b1;
  logic tdone = 1'b1, tfail = 1'b0, pin, fa, sw, reg_en, lp, oe_n;
  logic [7:0] st = 8'h00; // Fault stimulus bits
  logic [8:0] flags;
  logic pdat, oe_n_b, fa_b, sw_b; // Pin data; variant outputs
  logic [8:0] flags_b;
  int edges, num_errors = 0, check_count = 0, cyc = 0;
  always #20 clk = ~clk;
  fsr_supervisor #(.SUST_OC_CYC(20), .RETRY_CYC(7600)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_disable_fault_pin(pin),
    .i_ls_overcurrent(st[0]), .i_ls_conducting(st[0]),
    .i_peak_overcurrent(st[1]), .i_input_overvoltage(st[2]),
    .i_thermal_over(st[3]), .i_prog_check_active(st[4]),
    .i_prog_in_range_band(st[4]), .i_prog_check_done(st[5]),
    .i_prog_above_open(st[5]), .i_prog_below_short(st[6]),
    .i_freq_pin_below_short(st[7]), .i_trim_check_done(tdone),
    .i_trim_check_fail(tfail), .o_disable_fault_pin_out(pdat),
    .o_disable_fault_pin_oe_n(oe_n), .o_switch_enable(sw),
    .o_regulator_enable(reg_en), .o_low_power(lp), .o_freq_pin_hold(),
    .o_fault_active(fa), .o_fault_flags(flags));
  // Variant build: sustained overcurrent has no action; own pin loop
  fsr_supervisor #(.SUST_OC_CYC(20), .RETRY_CYC(7600),
    .SUST_OC_ACTION(1'b0)) dut_b (
    .i_ref_clk(clk), .i_rst(rst), .i_disable_fault_pin(oe_n_b),
    .i_ls_overcurrent(st[0]), .i_ls_conducting(st[0]),
    .i_peak_overcurrent(st[1]), .i_input_overvoltage(st[2]),
    .i_thermal_over(st[3]), .i_prog_check_active(st[4]),
    .i_prog_in_range_band(st[4]), .i_prog_check_done(st[5]),
    .i_prog_above_open(st[5]), .i_prog_below_short(st[6]),
    .i_freq_pin_below_short(st[7]), .i_trim_check_done(tdone),
    .i_trim_check_fail(tfail), .o_disable_fault_pin_out(),
    .o_disable_fault_pin_oe_n(oe_n_b), .o_switch_enable(sw_b),
    .o_regulator_enable(), .o_low_power(), .o_freq_pin_hold(),
    .o_fault_active(fa_b), .o_fault_flags(flags_b));
  fsr_ctrl_model ctrl (.i_ref_clk(clk), .i_oe_n(oe_n),
    .i_pull_low(pull_low), .i_fa(fa), .i_clr(clr), .o_pin(pin),
    .o_edges(edges));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Run needs about 88k cycles; a hang ends here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      conclude();
    end
  end
  // Controller keeps the pin free during codes
  task automatic run_row(input fsr_row_type r);
    while (!sw) @(negedge clk);
    @(posedge clk) begin
      clr <= 1'b0;
      st <= r.st;
    end
    while (!fa) @(negedge clk);
    repeat (4) @(negedge clk);
    check(flags, r.fl);
    if (r.fl[0]) check({fa_b, sw_b, flags_b[6:0]}, 9'h080);
    check({7'h00, pdat, sw}, 9'h000);
    @(posedge clk) st <= 8'h00;
    while (!lp) @(negedge clk);
    check({7'h00, oe_n, reg_en}, 9'h001);
    while (fa) @(negedge clk);
    check(edges[8:0], r.ed[8:0]);
    @(posedge clk) clr <= 1'b1;
  endtask : run_row
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({oe_n, sw, reg_en, flags[5:0]}, 9'h040);
    foreach (rows[i]) run_row(rows[i]);
    // Outside disable while running
    while (!sw) @(negedge clk);
    @(posedge clk) pull_low <= 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, sw, lp, reg_en}, 9'h003);
    @(posedge clk) pull_low <= 1'b0;
    // Fault still present at recheck
    while (!sw) @(negedge clk);
    @(posedge clk) st <= 8'h08;
    while (!fa) @(negedge clk);
    while (fa) @(negedge clk);
    while (!fa) @(negedge clk);
    repeat (4) @(negedge clk);
    check({sw, flags[7:0]}, 9'h008);
    // Power cycle in mid-fault with a failed trim read
    @(posedge clk) begin
      rst <= 1'b1;
      tfail <= 1'b1;
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    while (!fa) @(negedge clk);
    repeat (4) @(negedge clk);
    check(flags, 9'h100);
    while (fa) @(negedge clk);
    while (!fa) @(negedge clk);
    repeat (4) @(negedge clk);
    check(flags, 9'h100);
    conclude();
  end
endmodule : tb_top
